/* core/mode_ctrl_pkg.sv */
// Constants and types shared by the transceiver mode controller.
// Assumes a single clock domain running at 20 MHz.
package mode_ctrl_pkg;

  localparam int CLK_HZ = 20_000_000;

  // Go-to-sleep hold window in microseconds, and its cycle count (round down)
  localparam int SLEEP_HOLD_US = 50;
  localparam int SLEEP_HOLD_CYC = (SLEEP_HOLD_US * (CLK_HZ / 1_000_000) > 0)
    ? SLEEP_HOLD_US * (CLK_HZ / 1_000_000) : 1;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] HOLD_OFS = 8'h08;

  // Control register fields
  localparam int CTRL_WAKE_CLR_BIT = 0;
  localparam int CTRL_FAIL_CLR_BIT = 1;
  localparam int CTRL_PUP_CLR_BIT = 2;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_WAKE_BIT = 5;
  localparam int ST_FAIL_BIT = 6;
  localparam int ST_PUP_BIT = 7;
  localparam int ST_SUPPRESS_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    MODE_NORMAL = 5'b00001,
    MODE_RXONLY = 5'b00010,
    MODE_STANDBY = 5'b00100,
    MODE_GOSLEEP = 5'b01000,
    MODE_SLEEP = 5'b10000
  } mode_t;

  // Supply monitor levels
  typedef struct packed {
    logic batt_uv;
    logic core_uv;
    logic logic_uv;
  } supply_t;

  // Pins shared with the host controller
  typedef struct packed {
    logic enable;
    logic standby_control_n;
  } mode_pins_t;

  // Which functions are enabled in the present mode
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic lp_rx_en;
    logic local_wake_en;
    logic diag_en;
    logic inhibit_on;
  } func_t;

endpackage : mode_ctrl_pkg

/* core/can_transceiver_mode_control.sv */
// Mode controller of a high-speed bus transceiver with wake and diagnostics.
// Assumes pins and supply monitors are asynchronous; wake and failure
// detection arrive as already-filtered pulses from analog front-end logic.
// Overview of operation
// RL1: Enable high and standby control high selects normal operation.
// RL2: Enable low with standby control high selects receive-only mode.
// RL3: Receive-only blocks transmit data; receiver still forwards.
// RL4: Active receiver drives receive data low for dominant, high recessive.
// RL5: Receive-only keeps low-power receiver and local wake off, inhibit on.
// RL6: Receive-only shows latched local failures low on error output.
// RL7: After power-up the device enters stand-by on its own.
// RL8: Stand-by disables transmitter, receiver, transmit input, diagnostics.
// RL9: Stand-by bus message sets wake flag, shown low when supplies present.
// RL10: Wake indication suppressed after power-up and battery undervoltage.
// RL11: Stand-by local wake input active, event shown on outputs.
// RL12: Stand-by reports power-up event on error output.
// RL13: Both pins low from normal or receive-only selects stand-by.
// RL14: Standby control low with enable high enters go-to-sleep.
// RL15: Go-to-sleep lasts at most the hold window, then sleep.
// RL16: Enable low inside the hold window returns to stand-by.
// RL17: Sleep is reached from pins only through go-to-sleep.
// RL18: Go-to-sleep keeps wake detection active and inhibit on.
// RL19: Bus wake in sleep sets wake flag and enters stand-by.
// RL20: Local wake change in sleep enters stand-by; inhibit floats.
// RL21: Battery undervoltage forces stand-by from every mode.
// RL22: Transceiver or logic supply undervoltage forces sleep.
// RL23: Pin mode changes accepted only with both supplies present.
// RL24: Mode changes never depend on the bus state.
// RL25: Pins synchronised; hold window counted in clock cycles.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module can_transceiver_mode_control
  import mode_ctrl_pkg::*;
#(
  parameter int HOLD_CYC = SLEEP_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host pins
  input wire mode_ctrl_pkg::mode_pins_t pins,
  input wire logic txd,
  output logic rxd,
  output logic error_flag_out_n,
  // Bus side
  input wire logic bus_dominant,
  output logic bus_drive_dominant,
  input wire logic bus_wake_event,
  input wire logic local_wake_input,
  input wire logic local_failure,
  // Supplies
  input wire mode_ctrl_pkg::supply_t supply,
  // Inhibit pin: out drives battery level while oe high, floats otherwise
  output logic inhibit_output,
  output logic inhibit_output_oe,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mode_ctrl_pkg::*;

  // Two-stage synchronisers for all asynchronous inputs
  localparam int NS = 10;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] async_in;
  assign async_in = {pins.enable, pins.standby_control_n, txd, bus_dominant,
    bus_wake_event, local_wake_input, local_failure, supply.batt_uv,
    supply.core_uv, supply.logic_uv};

  always_ff @(posedge mclk) begin // RL25
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  logic en_s, stb_s, txd_s, dom_s, bwake_s, lwake_s, fail_s;
  logic batt_uv_s, core_uv_s, logic_uv_s;
  assign {en_s, stb_s, txd_s, dom_s, bwake_s, lwake_s, fail_s, batt_uv_s,
    core_uv_s, logic_uv_s} = sync2_r;

  // Pin modes act only while transceiver and logic supplies are up
  logic supplies_ok;
  assign supplies_ok = !core_uv_s && !logic_uv_s;

  // Edge detection on synchronised signals
  // Registers reset to the idle pin levels so no false edge follows reset
  logic lwake_d_r, bwake_d_r, batt_uv_d_r, en_d_r, stb_d_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      lwake_d_r <= 1'b0;
      bwake_d_r <= 1'b0;
      batt_uv_d_r <= 1'b0;
      en_d_r <= 1'b0;
      stb_d_r <= 1'b0;
    end else begin
      lwake_d_r <= lwake_s;
      bwake_d_r <= bwake_s;
      batt_uv_d_r <= batt_uv_s;
      en_d_r <= en_s;
      stb_d_r <= stb_s;
    end
  end

  logic lwake_chg, bwake_rise, batt_uv_rise, pins_chg;
  assign lwake_chg = lwake_s ^ lwake_d_r;
  assign bwake_rise = bwake_s && !bwake_d_r;
  assign batt_uv_rise = batt_uv_s && !batt_uv_d_r;
  assign pins_chg = (en_s ^ en_d_r) || (stb_s ^ stb_d_r);

  // Mode state machine
  mode_t mode_r, mode_nxt;
  logic [31:0] hold_cfg_r;
  logic [31:0] hold_cnt_r;
  logic hold_done;
  // Window ends when the count reaches one less than the programmed cycle total
  assign hold_done = (hold_cnt_r + 32'h0000_0001) >= hold_cfg_r;

  // Mode selected by the pin pair; sleep is never a direct target
  function automatic mode_t pin_mode(input logic en, input logic stb,
                                     input mode_t cur);
    mode_t m;
    m = cur;
    if (en && stb) begin
      m = MODE_NORMAL; // RL1
    end else if (!en && stb) begin
      m = MODE_RXONLY; // RL2
    end else if (en && !stb) begin
      if (cur != MODE_SLEEP) m = MODE_GOSLEEP; // RL14
    end else begin
      if (cur == MODE_NORMAL || cur == MODE_RXONLY || cur == MODE_GOSLEEP)
        m = MODE_STANDBY; // RL13 RL16
    end
    return m;
  endfunction

  // Battery undervoltage outranks logic undervoltage; wakes outrank pins
  always_comb begin
    mode_nxt = mode_r;
    // Bus level never enters this decision
    if (batt_uv_s) begin // RL24
      mode_nxt = MODE_STANDBY; // RL21
    end else if (!supplies_ok) begin
      mode_nxt = MODE_SLEEP; // RL22
    end else begin
      unique case (mode_r)
        MODE_SLEEP: begin
          if (bwake_rise || lwake_chg) begin
            mode_nxt = MODE_STANDBY; // RL19 RL20
          end else if (pins_chg && stb_s) begin
            mode_nxt = pin_mode(en_s, stb_s, mode_r); // RL23
          end
        end
        MODE_GOSLEEP: begin
          if (!en_s || stb_s) begin
            mode_nxt = pin_mode(en_s, stb_s, mode_r); // RL16
          end else if (hold_done) begin
            mode_nxt = MODE_SLEEP; // RL15 RL17
          end
        end
        default: begin
          mode_nxt = pin_mode(en_s, stb_s, mode_r); // RL23
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) mode_r <= MODE_STANDBY; // RL7
    else mode_r <= mode_nxt;
  end

  // Counter runs only in go-to-sleep and restarts on every entry
  always_ff @(posedge mclk) begin
    if (rst || mode_r != MODE_GOSLEEP) hold_cnt_r <= 32'h0;
    else hold_cnt_r <= hold_cnt_r + 32'h0000_0001; // RL15
  end

  // Per-mode function enables
  func_t fn;
  always_comb begin
    fn = '0;
    unique case (mode_r)
      MODE_NORMAL: fn = 6'b110011;
      MODE_RXONLY: fn = 6'b010011; // RL3 RL5
      MODE_STANDBY: fn = 6'b001101; // RL8 RL11
      MODE_GOSLEEP: fn = 6'b001101; // RL18
      MODE_SLEEP: fn = 6'b001100; // RL20
      default: fn = 6'b001101;
    endcase
  end

  // Flags: hardware set wins over software clear
  logic wake_r, fail_r, pup_r, suppress_r;
  logic wake_clr, fail_clr, pup_clr;
  logic wake_set;
  assign wake_set = fn.lp_rx_en && (bwake_rise || (fn.local_wake_en &&
    lwake_chg)); // RL9 RL11 RL19

  always_ff @(posedge mclk) begin
    if (rst) wake_r <= 1'b0;
    else if (wake_set) wake_r <= 1'b1;
    else if (wake_clr || mode_r == MODE_NORMAL) wake_r <= 1'b0;
  end

  // Failures latch only while diagnostics run; leaving receive-only
  // for normal releases them
  always_ff @(posedge mclk) begin
    if (rst) fail_r <= 1'b0;
    else if (fail_s && fn.diag_en) fail_r <= 1'b1;
    else if (fail_clr || (mode_r == MODE_RXONLY && mode_nxt == MODE_NORMAL))
      fail_r <= 1'b0;
  end

  // Power-up flag; wake indication suppressed until the first wake event or pin change
  always_ff @(posedge mclk) begin
    if (rst) pup_r <= 1'b1; // RL12
    else if (batt_uv_rise) pup_r <= 1'b1;
    else if (pup_clr || mode_r == MODE_NORMAL) pup_r <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) suppress_r <= 1'b1; // RL10
    else if (batt_uv_rise) suppress_r <= 1'b1;
    else if (wake_set || pins_chg) suppress_r <= 1'b0;
  end

  // Pin outputs
  logic wake_show;
  assign wake_show = wake_r && !suppress_r && supplies_ok; // RL9 RL10

  // Receiver data when the receiver runs, wake indication otherwise
  always_ff @(posedge mclk) begin
    if (rst) rxd <= 1'b1;
    else if (fn.rx_en) rxd <= !dom_s; // RL4
    else rxd <= !wake_show; // RL9 RL11
  end

  // Failure shown in normal and receive-only, power-up or wake elsewhere
  always_ff @(posedge mclk) begin
    if (rst) error_flag_out_n <= 1'b1;
    else if (fn.diag_en) error_flag_out_n <= !fail_r; // RL6
    else error_flag_out_n <= !(wake_show || pup_r); // RL11 RL12
  end

  always_ff @(posedge mclk) begin
    if (rst) bus_drive_dominant <= 1'b0;
    else bus_drive_dominant <= fn.tx_en && !txd_s; // RL3 RL8
  end

  // Inhibit floats only in sleep
  always_ff @(posedge mclk) begin
    if (rst) begin
      inhibit_output <= 1'b1;
      inhibit_output_oe <= 1'b1;
    end else begin
      inhibit_output <= fn.inhibit_on;
      inhibit_output_oe <= fn.inhibit_on; // RL5 RL20
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

  // Address and data may arrive in either order; the response
  // waits until both are held
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r[7:2] <= HOLD_OFS[7:2]) ? RESP_OKAY
          : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Word-aligned register match on the upper address bits
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

  logic ctrl_wr;
  assign ctrl_wr = do_write && reg_hit(awaddr_r, CTRL_OFS) && wstrb_r[0];
  assign wake_clr = ctrl_wr && wdata_r[CTRL_WAKE_CLR_BIT];
  assign fail_clr = ctrl_wr && wdata_r[CTRL_FAIL_CLR_BIT];
  assign pup_clr = ctrl_wr && wdata_r[CTRL_PUP_CLR_BIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cfg_r <= 32'(HOLD_CYC);
    end else if (do_write && reg_hit(awaddr_r, HOLD_OFS)) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_r[i]) hold_cfg_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
      end
    end
  end

  // Read data is registered and held until the master takes it
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      unique case (s_axi_araddr[7:2])
        CTRL_OFS[7:2]: s_axi_rdata <= 32'h0;
        STATUS_OFS[7:2]: begin
          s_axi_rdata[ST_MODE_LSB +: 5] <= mode_r;
          s_axi_rdata[ST_WAKE_BIT] <= wake_r;
          s_axi_rdata[ST_FAIL_BIT] <= fail_r;
          s_axi_rdata[ST_PUP_BIT] <= pup_r;
          s_axi_rdata[ST_SUPPRESS_BIT] <= suppress_r;
        end
        HOLD_OFS[7:2]: s_axi_rdata <= hold_cfg_r;
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // can_transceiver_mode_control

`default_nettype wire

/* dv/mode_ctrl_props.sv */
// Concurrent checks on the mode controller's top-level ports.
// Assumes one clock, mclk, and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_props
  import mode_ctrl_pkg::*;
#(parameter int HOLD_CYC = 8) (
  // Clock, reset and inputs
  input wire logic mclk, rst, txd, bus_dominant, bus_wake_event,
  input wire logic local_wake_input,
  input wire mode_ctrl_pkg::mode_pins_t pins,
  input wire mode_ctrl_pkg::supply_t supply,
  // Outputs
  input wire logic rxd, error_flag_out_n, bus_drive_dominant,
  input wire logic inhibit_output_oe,
  // AXI4-Lite
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  import mode_ctrl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  int cnt;
  logic uv_seen;
  // Length of an undisturbed go-to-sleep request
  always_ff @(posedge mclk) begin
    if (rst || pins != 2'h2 || supply != 3'h0 || bus_wake_event ||
        $changed(local_wake_input))
      cnt <= 0;
    else if (cnt < 1000)
      cnt <= cnt + 1;
  end
  always_ff @(posedge mclk) begin
    if (rst)
      uv_seen <= 1'h0;
    else if (supply.core_uv || supply.logic_uv)
      uv_seen <= 1'h1;
  end
  a_tx_blocked: assert property (!pins.enable [*5] |->
    !bus_drive_dominant) else $error("transmit active, enable low");
  a_tx_normal: assert property (
    (pins == 2'h3 && supply == 3'h0 && !txd) [*6] |-> bus_drive_dominant)
    else $error("normal mode does not transmit");
  a_rx_follow: assert property (
    (pins.standby_control_n && supply == 3'h0 && $stable(bus_dominant)) [*6]
    |-> rxd == !bus_dominant) else $error("receive data wrong");
  a_rst_state: assert property (disable iff (1'h0) rst |=>
    inhibit_output_oe && !bus_drive_dominant && !s_axi_bvalid &&
    !s_axi_rvalid) else $error("reset state wrong");
  a_pup_err: assert property (disable iff (1'h0)
    rst ##1 !rst |=> !error_flag_out_n) else $error("power-up not shown");
  a_sleep_min: assert property (
    $fell(inhibit_output_oe) && !uv_seen |-> cnt >= HOLD_CYC)
    else $error("sleep entered before hold window");
  a_sleep_max: assert property (
    cnt == HOLD_CYC + 10 && !uv_seen |-> !inhibit_output_oe)
    else $error("sleep not entered after hold window");
  a_gosleep_inh: assert property (
    cnt > 0 && cnt < HOLD_CYC |-> inhibit_output_oe)
    else $error("inhibit released in go-to-sleep");
  a_abort_stby: assert property (
    cnt > 0 && cnt < 4 ##1 pins == 2'h0 |-> inhibit_output_oe [*8])
    else $error("abort did not keep inhibit");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] > HOLD_OFS[7:2] |=> s_axi_rvalid &&
    s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read answered wrongly");
  c_sleep: cover property ($fell(inhibit_output_oe));
  c_abort: cover property (cnt == 2 ##1 pins == 2'h0);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // mode_ctrl_props
bind can_transceiver_mode_control mode_ctrl_props #(.HOLD_CYC(HOLD_CYC))
  i_props (.*);
`default_nettype wire

/* dv/host_model.sv */
// Host controller model: drives the mode pins and transmit data.
// Assumes the bench states the wanted levels; they change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import mode_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wanted levels
  input wire mode_ctrl_pkg::mode_pins_t want_pins,
  input wire logic want_txd,
  // Pins
  output var mode_ctrl_pkg::mode_pins_t pins,
  output var logic txd
);
  import mode_ctrl_pkg::*;
  // Pins idle low in reset, like the pulled-down standby pin
  always_ff @(posedge mclk) begin
    pins <= rst ? 2'h0 : want_pins;
  end
  always_ff @(posedge mclk) begin
    txd <= rst ? 1'h1 : want_txd;
  end
endmodule // host_model
`default_nettype wire

/* dv/can_transceiver_mode_control_tb_top.sv */
// Self-checking bench of the transceiver mode controller.
// Assumes a 50 ns clock and registers reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_control_tb_top;
  import mode_ctrl_pkg::*;
  localparam int HOLD = 8;
  typedef struct packed {
    logic [1:0] p;
    logic bd;
    logic [4:0] m;
    logic drv;
    logic rx;
  } row_t;
  row_t rows [6] = '{'{2'h3, 1'h1, 5'h01, 1'h1, 1'h0},
    '{2'h1, 1'h0, 5'h02, 1'h0, 1'h1}, '{2'h0, 1'h1, 5'h04, 1'h0, 1'h1},
    '{2'h3, 1'h0, 5'h01, 1'h1, 1'h1}, '{2'h1, 1'h1, 5'h02, 1'h0, 1'h0},
    '{2'h0, 1'h0, 5'h04, 1'h0, 1'h1}};
  logic mclk = 1'h0, rst = 1'h1, want_txd = 1'h0, bus_dominant = 1'h0;
  logic bus_wake_event = 1'h0, local_wake_input = 1'h0, local_failure = 1'h0;
  logic txd, rxd, error_flag_out_n, bus_drive_dominant;
  logic inhibit_output, inhibit_output_oe;
  mode_pins_t want_pins = 2'h0, pins;
  supply_t supply = 3'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int num_errors = 0, samples_checked = 0, n;
  always #25 mclk = ~mclk;
  host_model i_host (.*);
  can_transceiver_mode_control #(.HOLD_CYC(HOLD)) i_dut (.*);
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    logic ta, tw, tb;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tb = 1'h0;
    for (k = 0; k < 40 && !tb; k++) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    if (!tb) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    logic ta, tr;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tr = 1'h0;
    for (k = 0; k < 40 && !tr; k++) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    if (!tr) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic go(input mode_pins_t p, input int c);
    @(posedge mclk);
    want_pins <= p;
    wt(c);
  endtask
  task automatic md(input logic [4:0] m);
    rd(STATUS_OFS);
    chk(v[4:0], m);
  endtask
  task automatic slp();
    go(2'h2, 4);
    for (n = 0; n < 40 && inhibit_output_oe; n++) @(negedge mclk);
    chk(inhibit_output_oe, 1'h0);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    wt(1);
    chk(error_flag_out_n, 1'h0);
    chk(rxd, 1'h1);
    rd(STATUS_OFS);
    chk(v, 32'h184);
    rd(HOLD_OFS);
    chk(v, HOLD);
    rd(8'h0C);
    chk(r, RESP_SLVERR);
    wr(8'h10, 32'hFFFFFFFF);
    chk(r, RESP_SLVERR);
    // Mode table, bus level varied per row
    foreach (rows[i]) begin
      @(posedge mclk);
      bus_dominant <= rows[i].bd;
      go(rows[i].p, 8);
      chk(bus_drive_dominant, rows[i].drv);
      chk(rxd, rows[i].rx);
      chk(error_flag_out_n, 1'h1);
      md(rows[i].m);
    end
    @(posedge mclk);
    bus_wake_event <= 1'h1;
    @(posedge mclk);
    bus_wake_event <= 1'h0;
    wt(6);
    chk(rxd, 1'h0);
    chk(error_flag_out_n, 1'h0);
    wr(CTRL_OFS, 32'h1);
    wt(3);
    chk(rxd, 1'h1);
    go(2'h0, 1);
    local_wake_input <= 1'h1;
    wt(6);
    chk(rxd, 1'h0);
    wr(CTRL_OFS, 32'h1);
    go(2'h1, 8);
    local_failure <= 1'h1;
    go(2'h1, 1);
    local_failure <= 1'h0;
    wt(4);
    chk(error_flag_out_n, 1'h0);
    go(2'h3, 8);
    go(2'h0, 8);
    go(2'h2, 4);
    chk(inhibit_output_oe, 1'h1);
    md(MODE_GOSLEEP);
    for (n = 0; n < 40 && inhibit_output_oe; n++) @(negedge mclk);
    chk(inhibit_output_oe, 1'h0);
    chk(inhibit_output, 1'h0);
    go(2'h0, 6);
    md(MODE_SLEEP);
    go(2'h0, 1);
    local_wake_input <= 1'h0;
    wt(6);
    md(MODE_STANDBY);
    chk(inhibit_output_oe, 1'h1);
    chk(inhibit_output, 1'h1);
    go(2'h2, 1);
    go(2'h0, 8);
    md(MODE_STANDBY);
    slp();
    go(2'h0, 4);
    bus_wake_event <= 1'h1;
    go(2'h0, 1);
    bus_wake_event <= 1'h0;
    wt(6);
    rd(STATUS_OFS);
    chk(v[5:0], 6'h24);
    go(2'h0, 1);
    supply.core_uv <= 1'h1;
    wt(6);
    md(MODE_SLEEP);
    go(2'h3, 8);
    md(MODE_SLEEP);
    go(2'h0, 2);
    supply.batt_uv <= 1'h1;
    wt(6);
    md(MODE_STANDBY);
    go(2'h0, 1);
    supply <= 3'h0;
    wt(6);
    rd(STATUS_OFS);
    chk(v[8], 1'h1);
    give_verdict();
  end
endmodule // can_transceiver_mode_control_tb_top
`default_nettype wire
